//--- adc_convert_start_read_control.sv
`timescale 1ns/10ps
`default_nettype none
module adc_convert_start_read_control (
  input wire logic ref_clk, // 250 MHz block clock
  input wire logic resetn, // sync reset, active low
  input wire logic wr_strobe_n, // start strobe pin
  input wire logic read_n, // serial read gate pin
  input wire logic channel_reselect, // take new channel
  input wire logic [3:0] channel_addr, // channel address pins
  input wire logic serial_shift_clock, // shift clock pin
  input wire logic [11:0] sample_value, // converter core word
  output logic settling_flag, // settling in progress
  output logic converting_flag, // conversion in progress
  output logic serial_result_out, // serial data bit
  output logic serial_result_oe_n, // low while driving
  output logic [3:0] selected_channel, // mux select
  output logic irq, // level interrupt
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready // read data ready
);
  edge_sync_if wr_if ();
  edge_sync_if rd_if ();
  edge_sync_if sck_if ();

  // every pin passes two flops before use
  edge_sync #(.INIT(1'b1)) wr_sync (
    .clk(ref_clk),
    .resetn(resetn),
    .async_in(wr_strobe_n),
    .sig(wr_if)
  );
  edge_sync #(.INIT(1'b1)) rd_sync (
    .clk(ref_clk),
    .resetn(resetn),
    .async_in(read_n),
    .sig(rd_if)
  );
  edge_sync #(.INIT(1'b1)) sck_sync (
    .clk(ref_clk),
    .resetn(resetn),
    .async_in(serial_shift_clock),
    .sig(sck_if)
  );

  // reselect and address are only read at strobe edges, which the host
  // keeps stable there; their sync delay matches the strobe's
  logic sel_meta_reg, sel_meta_next;
  logic sel_sync_reg, sel_sync_next;
  logic [3:0] addr_meta_reg, addr_meta_next;
  logic [3:0] addr_sync_reg, addr_sync_next;

  adc_ctrl_pkg::conv_state_t state_reg, state_next;
  logic [adc_ctrl_pkg::CNT_W-1:0] cnt_reg, cnt_next;
  logic [3:0] chan_reg, chan_next;
  logic [11:0] held_reg, held_next;
  logic [11:0] result_reg, result_next;
  logic [11:0] shift_reg, shift_next;
  logic drive_reg, drive_next;
  logic settling_reg, settling_next;
  logic converting_reg, converting_next;
  logic sdo_reg, sdo_next;
  logic ev_done, ev_ignored, ev_settled;
  logic busy;

  // input capture flops for the level inputs
  always_comb
  begin
    sel_meta_next = channel_reselect;
    sel_sync_next = sel_meta_reg;
    addr_meta_next = channel_addr;
    addr_sync_next = addr_meta_reg;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      sel_meta_reg <= 1'b0;
      sel_sync_reg <= 1'b0;
      addr_meta_reg <= 4'h0;
      addr_sync_reg <= 4'h0;
    end
    else
    begin
      sel_meta_reg <= sel_meta_next;
      sel_sync_reg <= sel_sync_next;
      addr_meta_reg <= addr_meta_next;
      addr_sync_reg <= addr_sync_next;
    end
  end

  assign busy = (state_reg == adc_ctrl_pkg::ST_SETTLE) ||
                (state_reg == adc_ctrl_pkg::ST_CONVERT);

  // convert start sequencer; settle and convert times are the worst-case
  // limits, so any finer model of the analog path only shortens them
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    chan_next = chan_reg;
    held_next = held_reg;
    result_next = result_reg;
    ev_done = 1'b0;
    ev_ignored = 1'b0;
    ev_settled = 1'b0;
    unique case (state_reg)
      adc_ctrl_pkg::ST_IDLE:
      begin
        if (wr_if.fall)
        begin
          if (sel_sync_reg)
          begin
            chan_next = addr_sync_reg;
            cnt_next = adc_ctrl_pkg::SETTLE_LOAD;
            state_next = adc_ctrl_pkg::ST_SETTLE;
          end
          else
          begin
            state_next = adc_ctrl_pkg::ST_ARMED;
          end
        end
      end
      adc_ctrl_pkg::ST_SETTLE:
      begin
        if (wr_if.fall)
        begin
          ev_ignored = 1'b1;
        end
        if (cnt_reg == '0)
        begin
          ev_settled = 1'b1;
          if (wr_if.level)
          begin
            held_next = sample_value;
            cnt_next = adc_ctrl_pkg::CONVERT_LOAD;
            state_next = adc_ctrl_pkg::ST_CONVERT;
          end
          else
          begin
            state_next = adc_ctrl_pkg::ST_SETTLED;
          end
        end
        else
        begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      adc_ctrl_pkg::ST_SETTLED, adc_ctrl_pkg::ST_ARMED:
      begin
        if (wr_if.rise)
        begin
          held_next = sample_value;
          cnt_next = adc_ctrl_pkg::CONVERT_LOAD;
          state_next = adc_ctrl_pkg::ST_CONVERT;
        end
      end
      adc_ctrl_pkg::ST_CONVERT:
      begin
        if (wr_if.fall)
        begin
          ev_ignored = 1'b1;
        end
        if (cnt_reg == '0)
        begin
          result_next = held_reg;
          ev_done = 1'b1;
          state_next = adc_ctrl_pkg::ST_IDLE;
        end
        else
        begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      default:
      begin
        state_next = adc_ctrl_pkg::ST_IDLE;
      end
    endcase
    settling_next = (state_next == adc_ctrl_pkg::ST_SETTLE);
    converting_next = (state_next == adc_ctrl_pkg::ST_CONVERT);
  end

  // serial output: driver may stay on into a conversion, never turn on
  always_comb
  begin
    shift_next = shift_reg;
    drive_next = ~rd_if.level & (~busy | drive_reg);
    if (ev_done)
    begin
      shift_next = held_reg;
    end
    else if (sck_if.fall && !busy && drive_reg)
    begin
      shift_next = {shift_reg[10:0], 1'b0};
    end
    sdo_next = shift_next[11];
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      state_reg <= adc_ctrl_pkg::ST_IDLE;
      cnt_reg <= '0;
      chan_reg <= adc_ctrl_pkg::CHAN_RESET;
      held_reg <= adc_ctrl_pkg::RESULT_RESET;
      result_reg <= adc_ctrl_pkg::RESULT_RESET;
      shift_reg <= adc_ctrl_pkg::RESULT_RESET;
      drive_reg <= 1'b0;
      settling_reg <= 1'b0;
      converting_reg <= 1'b0;
      sdo_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      chan_reg <= chan_next;
      held_reg <= held_next;
      result_reg <= result_next;
      shift_reg <= shift_next;
      drive_reg <= drive_next;
      settling_reg <= settling_next;
      converting_reg <= converting_next;
      sdo_reg <= sdo_next;
    end
  end

  // register file and bus slave
  logic aw_have_reg, aw_have_next;
  logic awready_reg, awready_next;
  logic wready_reg, wready_next;
  logic [7:0] aw_addr_reg, aw_addr_next;
  logic w_have_reg, w_have_next;
  logic [31:0] w_data_reg, w_data_next;
  logic w_lane0_reg, w_lane0_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic arready_reg, arready_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [2:0] status_reg, status_next;
  logic [2:0] mask_reg, mask_next;
  logic [2:0] clr;
  logic irq_reg, irq_next;

  // write and read channels; set beats clear on the same status bit
  always_comb
  begin
    aw_have_next = aw_have_reg;
    aw_addr_next = aw_addr_reg;
    w_have_next = w_have_reg;
    w_data_next = w_data_reg;
    w_lane0_next = w_lane0_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    arready_next = arready_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    mask_next = mask_reg;
    clr = 3'h0;
    if (s_axi_awvalid && awready_reg)
    begin
      aw_have_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_reg)
    begin
      w_have_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_lane0_next = s_axi_wstrb[0];
    end
    if (aw_have_reg && w_have_reg && !bvalid_reg)
    begin
      aw_have_next = 1'b0;
      w_have_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = adc_ctrl_pkg::RESP_OKAY;
      unique case (aw_addr_reg)
        adc_ctrl_pkg::ADDR_STATUS:
          clr = w_lane0_reg ? w_data_reg[2:0] : 3'h0;
        adc_ctrl_pkg::ADDR_MASK:
          mask_next = w_lane0_reg ? w_data_reg[2:0] : mask_reg;
        adc_ctrl_pkg::ADDR_RESULT, adc_ctrl_pkg::ADDR_CHANNEL:
          bresp_next = adc_ctrl_pkg::RESP_OKAY; // read-only, write dropped
        default:
          bresp_next = adc_ctrl_pkg::RESP_SLVERR;
      endcase
    end
    else if (bvalid_reg && s_axi_bready)
    begin
      bvalid_next = 1'b0;
    end
    if (s_axi_arvalid && arready_reg)
    begin
      arready_next = 1'b0;
      rvalid_next = 1'b1;
      rresp_next = adc_ctrl_pkg::RESP_OKAY;
      rdata_next = 32'h00000000;
      unique case (s_axi_araddr)
        adc_ctrl_pkg::ADDR_STATUS: rdata_next[2:0] = status_reg;
        adc_ctrl_pkg::ADDR_MASK: rdata_next[2:0] = mask_reg;
        adc_ctrl_pkg::ADDR_RESULT: rdata_next[11:0] = result_reg;
        adc_ctrl_pkg::ADDR_CHANNEL:
        begin
          rdata_next[3:0] = chan_reg;
          rdata_next[adc_ctrl_pkg::CH_SETTLING_BIT] = settling_reg;
          rdata_next[adc_ctrl_pkg::CH_CONVERTING_BIT] = converting_reg;
        end
        default: rresp_next = adc_ctrl_pkg::RESP_SLVERR;
      endcase
    end
    else if (rvalid_reg && s_axi_rready)
    begin
      rvalid_next = 1'b0;
      arready_next = 1'b1;
    end
    status_next = (status_reg & ~clr) | {ev_settled, ev_ignored, ev_done};
    irq_next = |(status_next & mask_next);
    // readies worked out a cycle ahead so they leave a flop
    awready_next = ~aw_have_next & ~bvalid_next;
    wready_next = ~w_have_next & ~bvalid_next;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      aw_have_reg <= 1'b0;
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      aw_addr_reg <= 8'h00;
      w_have_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_lane0_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= adc_ctrl_pkg::RESP_OKAY;
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= adc_ctrl_pkg::RESP_OKAY;
      status_reg <= 3'h0;
      mask_reg <= adc_ctrl_pkg::MASK_RESET;
      irq_reg <= 1'b0;
    end
    else
    begin
      aw_have_reg <= aw_have_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      aw_addr_reg <= aw_addr_next;
      w_have_reg <= w_have_next;
      w_data_reg <= w_data_next;
      w_lane0_reg <= w_lane0_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      status_reg <= status_next;
      mask_reg <= mask_next;
      irq_reg <= irq_next;
    end
  end

  // outputs straight from flops
  assign settling_flag = settling_reg;
  assign converting_flag = converting_reg;
  assign serial_result_out = sdo_reg;
  assign serial_result_oe_n = ~drive_reg;
  assign selected_channel = chan_reg;
  assign irq = irq_reg;
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
endmodule
`default_nettype wire

//--- adc_ctrl_pkg.sv
`default_nettype none
package adc_ctrl_pkg;

  // clock and timing, times in ns
  localparam int CLK_MHZ = 250;
  localparam int SETTLE_TIME_NS = 10000;
  localparam int CONVERT_TIME_NS = 15000;
  localparam int FLAG_RISE_TIME_NS = 200;
  // longest times round down to whole cycles
  localparam int SETTLE_CYCLES = (SETTLE_TIME_NS * CLK_MHZ) / 1000;
  localparam int CONVERT_CYCLES = (CONVERT_TIME_NS * CLK_MHZ) / 1000;
  localparam int FLAG_RISE_CYCLES = (FLAG_RISE_TIME_NS * CLK_MHZ) / 1000;
  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] SETTLE_LOAD = CNT_W'(SETTLE_CYCLES - 1);
  localparam logic [CNT_W-1:0] CONVERT_LOAD = CNT_W'(CONVERT_CYCLES - 1);

  // data path widths
  localparam int RESULT_W = 12;
  localparam int CHAN_W = 4;
  localparam int ADDR_W = 8;

  // register byte offsets
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_MASK = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_RESULT = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_CHANNEL = 8'h0C;

  // status and mask bit positions
  localparam int EV_W = 3;
  localparam int EV_DONE = 0;
  localparam int EV_IGNORED = 1;
  localparam int EV_SETTLED = 2;
  // channel register field positions
  localparam int CH_SETTLING_BIT = 8;
  localparam int CH_CONVERTING_BIT = 9;

  // reset values
  localparam logic [EV_W-1:0] MASK_RESET = 3'h0;
  localparam logic [RESULT_W-1:0] RESULT_RESET = 12'h000;
  localparam logic [CHAN_W-1:0] CHAN_RESET = 4'h0;

  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETTLE = 3'b001,
    ST_SETTLED = 3'b010,
    ST_ARMED = 3'b011,
    ST_CONVERT = 3'b100
  } conv_state_t;

endpackage
`default_nettype wire

//--- edge_sync_if.sv
`timescale 1ns/10ps
`default_nettype none
interface edge_sync_if;
  logic level;
  logic rise;
  logic fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface
`default_nettype wire

//--- edge_sync.sv
`timescale 1ns/10ps
`default_nettype none
module edge_sync #(
  parameter logic INIT = 1'b1
) (
  input wire logic clk,      // block clock
  input wire logic resetn,   // synchronous reset, active low
  input wire logic async_in, // pin from outside the clock domain
  edge_sync_if.src sig       // synced level and edge pulses
);
  logic meta_reg, meta_next;
  logic sync_reg, sync_next;
  logic prev_reg, prev_next;

  // two flops, then edge detect on the second only
  always_comb
  begin
    meta_next = async_in;
    sync_next = meta_reg;
    prev_next = sync_reg;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      meta_reg <= INIT;
      sync_reg <= INIT;
      prev_reg <= INIT;
    end
    else
    begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      prev_reg <= prev_next;
    end
  end

  assign sig.level = sync_reg;
  assign sig.rise = sync_reg & ~prev_reg;
  assign sig.fall = ~sync_reg & prev_reg;
endmodule
`default_nettype wire

//--- adc_convert_chk.sv
`timescale 1ns/10ps
`default_nettype none
module adc_convert_chk (
  input wire logic ref_clk, // clock
  input wire logic resetn, // reset, low active
  input wire logic wr_strobe_n, // strobe pin
  input wire logic settling_flag, // settling
  input wire logic converting_flag, // converting
  input wire logic serial_result_oe_n, // low while driving
  input wire logic [3:0] selected_channel, // channel
  input wire logic s_axi_arvalid, // read addr valid
  input wire logic s_axi_arready, // read addr ready
  input wire logic s_axi_rvalid // read data valid
);
  logic [12:0] st_cnt_reg;
  logic [12:0] st_cnt_next;
  logic [12:0] cv_cnt_reg;
  logic [12:0] cv_cnt_next;

  // run length of each flag; 13 bits without saturation, so a stuck flag wraps after 8192 cycles
  always_comb
  begin
    st_cnt_next = settling_flag ? st_cnt_reg + 13'h1 : 13'h0;
    cv_cnt_next = converting_flag ? cv_cnt_reg + 13'h1 : 13'h0;
    if (!resetn)
    begin
      st_cnt_next = 13'h0;
      cv_cnt_next = 13'h0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    st_cnt_reg <= st_cnt_next;
    cv_cnt_reg <= cv_cnt_next;
  end

  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  // flags hand over, never overlap
  a_flags_apart: assert property (
    !(settling_flag && converting_flag))
    else $error("settling and converting overlap");
  a_settle_len: assert property (
    $fell(settling_flag) |-> st_cnt_reg == adc_ctrl_pkg::SETTLE_CYCLES)
    else $error("settling length off");
  a_settle_max: assert property (
    st_cnt_reg <= adc_ctrl_pkg::SETTLE_CYCLES)
    else $error("settling too long");
  a_conv_len: assert property (
    $fell(converting_flag) |-> cv_cnt_reg == adc_ctrl_pkg::CONVERT_CYCLES)
    else $error("conversion length off");
  a_conv_max: assert property (
    cv_cnt_reg <= adc_ctrl_pkg::CONVERT_CYCLES)
    else $error("conversion too long");
  // strobe already back high: conversion takes over at once
  a_conv_follows: assert property (
    $fell(settling_flag) && wr_strobe_n && $past(wr_strobe_n, 4)
      |-> converting_flag)
    else $error("no conversion at settling end");
  a_wait_rise: assert property (
    $fell(settling_flag) && !wr_strobe_n
      |-> !converting_flag ##1 !converting_flag)
    else $error("conversion before strobe rise");
  a_oe_locked: assert property (
    converting_flag && $past(converting_flag)
      && $past(serial_result_oe_n) |-> serial_result_oe_n)
    else $error("driver enabled while converting");
  a_chan_steady: assert property (
    (settling_flag && $past(settling_flag))
      || (converting_flag && $past(converting_flag))
      |-> $stable(selected_channel))
    else $error("channel moved while busy");
  a_rd_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");

  c_settle_path: cover property ($fell(settling_flag) && converting_flag);
  c_direct_path: cover property ($rose(converting_flag)
    && !$past(settling_flag));
  c_read: cover property (s_axi_arvalid && s_axi_arready);
endmodule

bind adc_convert_start_read_control adc_convert_chk chk_u (
  .ref_clk(ref_clk), .resetn(resetn), .wr_strobe_n(wr_strobe_n),
  .settling_flag(settling_flag), .converting_flag(converting_flag),
  .serial_result_oe_n(serial_result_oe_n),
  .selected_channel(selected_channel), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid)
);
`default_nettype wire

//--- host_pins_model.sv
`timescale 1ns/10ps
`default_nettype none
module host_pins_model (
  input wire logic ref_clk, // clock
  input wire logic serial_result_out, // serial bit
  output var logic wr_strobe_n, // start strobe
  output var logic read_n, // read gate
  output var logic channel_reselect, // take new channel
  output var logic [3:0] channel_addr, // channel address
  output var logic serial_shift_clock // shift clock
);
  // idle host: strobe and read high, shift clock parked high
  initial
  begin
    wr_strobe_n = 1'b1;
    read_n = 1'b1;
    channel_reselect = 1'b0;
    channel_addr = 4'h0;
    serial_shift_clock = 1'b1;
  end

  // strobe falls with reselect and address set up
  task automatic press(input logic sel, input logic [3:0] a);
    @(posedge ref_clk);
    channel_reselect <= sel;
    channel_addr <= a;
    wr_strobe_n <= 1'b0;
  endtask

  // address kept until the next press, so stable at this edge too
  task automatic lift;
    @(posedge ref_clk);
    wr_strobe_n <= 1'b1;
  endtask

  // read only moves when the bench asks
  task automatic set_read(input logic v);
    @(posedge ref_clk);
    read_n <= v;
  endtask

  // one frame of 125 ns clocks; bit sampled late in each high phase
  task automatic shift_word(output logic [11:0] w);
    for (int i = 11; i >= 0; i--)
    begin
      #62.5;
      w[i] = serial_result_out;
      serial_shift_clock = 1'b0;
      #62.5;
      serial_shift_clock = 1'b1;
    end
  endtask
endmodule
`default_nettype wire

//--- tb_adc_convert_start_read_control.sv
`timescale 1ns/10ps
`default_nettype none
module tb_adc_convert_start_read_control;
  localparam logic [7:0] UNMAPPED = 8'h10;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [11:0] sample_value = 12'h000;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic wr_strobe_n, read_n, channel_reselect, serial_shift_clock;
  logic [3:0] channel_addr, selected_channel, a;
  logic settling_flag, converting_flag, serial_result_out;
  logic serial_result_oe_n, irq, saw_settle;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, q;
  logic [11:0] smp, prev, w;
  int n_fail = 0;
  int checked = 0;
  int seed = 30;
  int n;

  initial
  begin
    forever #2 ref_clk = ~ref_clk;
  end

  adc_convert_start_read_control dut_u (
    .ref_clk(ref_clk), .resetn(resetn), .wr_strobe_n(wr_strobe_n),
    .read_n(read_n), .channel_reselect(channel_reselect),
    .channel_addr(channel_addr), .serial_shift_clock(serial_shift_clock),
    .sample_value(sample_value), .settling_flag(settling_flag),
    .converting_flag(converting_flag),
    .serial_result_out(serial_result_out),
    .serial_result_oe_n(serial_result_oe_n),
    .selected_channel(selected_channel), .irq(irq),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready)
  );

  host_pins_model host_u (
    .ref_clk(ref_clk), .serial_result_out(serial_result_out),
    .wr_strobe_n(wr_strobe_n), .read_n(read_n),
    .channel_reselect(channel_reselect), .channel_addr(channel_addr),
    .serial_shift_clock(serial_shift_clock)
  );

  function automatic logic [3:0] exp_chan(input logic sel,
    input logic [3:0] ad, input logic [3:0] old);
    return sel ? ad : old;
  endfunction

  function automatic logic exp_irq(input logic [2:0] st, input logic [2:0] mk);
    return |(st & mk);
  endfunction

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp,
    input string m);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp,
    input string m);
    chk_val(32'(got), 32'(exp), m);
  endtask

  // one transfer; each channel dropped at its own handshake
  task automatic axi(input logic wr, input logic [7:0] ad,
    input logic [31:0] d);
    @(posedge ref_clk);
    s_axi_awaddr <= ad;
    s_axi_araddr <= ad;
    s_axi_wdata <= d;
    s_axi_wstrb <= {3'($random(seed)), 1'b1};
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_bready <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready <= !wr;
    do
    begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(wr ? s_axi_bvalid : s_axi_rvalid));
    q = s_axi_rdata;
    r = wr ? s_axi_bresp : s_axi_rresp;
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
  endtask

  // bounded wait on a flag, noting any settling seen meanwhile
  task automatic wait_for(input logic cv, input logic lvl);
    n = 0;
    while ((cv ? converting_flag : settling_flag) !== lvl && n < 6000)
    begin
      @(negedge ref_clk);
      n++;
      if (settling_flag === 1'b1) saw_settle = 1'b1;
    end
    if (n >= 6000) n_fail++;
  endtask

  task automatic close_out;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (4) @(negedge ref_clk);
    chk_val({settling_flag, converting_flag, serial_result_oe_n, irq},
      32'h2, "reset outputs");
    axi(1'b0, adc_ctrl_pkg::ADDR_MASK, 32'h0);
    chk_val(q, 32'h0, "mask reset");
    axi(1'b1, adc_ctrl_pkg::ADDR_MASK, 32'h1);
    // new channel; a second start lands during settling
    a = 4'($random(seed));
    smp = 12'($random(seed));
    host_u.press(1'b1, a);
    sample_value <= smp;
    repeat (20 + ($random(seed) & 7)) @(posedge ref_clk);
    host_u.lift;
    wait_for(1'b0, 1'b1);
    chk_val(32'(selected_channel), 32'(exp_chan(1'b1, a, '0)), "latch");
    host_u.press(1'b1, ~a);
    repeat (20) @(posedge ref_clk);
    host_u.lift;
    wait_for(1'b0, 1'b0);
    chk_val(32'(converting_flag), 32'h1, "convert at settle end");
    chk_val(32'(selected_channel), 32'(a), "busy start");
    @(posedge ref_clk);
    sample_value <= ~smp;
    wait_for(1'b1, 1'b0);
    axi(1'b0, adc_ctrl_pkg::ADDR_RESULT, 32'h0);
    chk_val(q, 32'(smp), "result word");
    chk_val(32'(irq), 32'(exp_irq(3'h7, 3'h1)), "irq done");
    axi(1'b0, adc_ctrl_pkg::ADDR_STATUS, 32'h0);
    chk_val(q, 32'h7, "status events");
    axi(1'b1, adc_ctrl_pkg::ADDR_STATUS, 32'h7);
    // same channel, read held low across the conversion
    prev = smp;
    host_u.set_read(1'b0);
    repeat (6) @(negedge ref_clk);
    chk_val({serial_result_oe_n, serial_result_out}, {prev[11]}, "pre");
    smp = 12'($random(seed));
    saw_settle = 1'b0;
    host_u.press(1'b0, ~a);
    sample_value <= smp;
    repeat (20) @(posedge ref_clk);
    host_u.lift;
    wait_for(1'b1, 1'b1);
    chk_val(32'(n <= adc_ctrl_pkg::FLAG_RISE_CYCLES), 32'h1, "rise");
    chk_val(32'(saw_settle), 32'h0, "no settling");
    chk_val(32'(selected_channel), 32'(exp_chan(1'b0, ~a, a)), "kept");
    chk_val({serial_result_oe_n, serial_result_out}, {prev[11]}, "old");
    @(posedge ref_clk);
    sample_value <= ~smp;
    wait_for(1'b1, 1'b0);
    repeat (2) @(negedge ref_clk);
    host_u.shift_word(w);
    chk_val(32'(w), 32'(smp), "serial word");
    host_u.set_read(1'b1);
    // strobe held past settling, read dropped mid-conversion
    a = 4'($random(seed));
    smp = 12'($random(seed));
    host_u.press(1'b1, a);
    sample_value <= smp;
    wait_for(1'b0, 1'b1);
    wait_for(1'b0, 1'b0);
    repeat (4) @(negedge ref_clk);
    chk_val(32'(converting_flag), 32'h0, "held strobe");
    host_u.lift;
    wait_for(1'b1, 1'b1);
    chk_val(32'(n <= 8), 32'h1, "convert at rise");
    host_u.set_read(1'b0);
    sample_value <= ~smp;
    repeat (10) @(negedge ref_clk);
    chk_val(32'(serial_result_oe_n), 32'h1, "enable while busy");
    wait_for(1'b1, 1'b0);
    repeat (6) @(negedge ref_clk);
    chk_val({serial_result_oe_n, serial_result_out}, {smp[11]}, "new");
    host_u.set_read(1'b1);
    axi(1'b0, adc_ctrl_pkg::ADDR_CHANNEL, 32'h0);
    chk_val(q, 32'(a), "channel reg");
    // bus corners and interrupt masking
    axi(1'b0, UNMAPPED, 32'h0);
    chk_resp(r, adc_ctrl_pkg::RESP_SLVERR, "rd unmapped");
    chk_val(q, 32'h0, "rd unmapped data");
    axi(1'b1, UNMAPPED, 32'h1);
    chk_resp(r, adc_ctrl_pkg::RESP_SLVERR, "wr unmapped");
    axi(1'b1, adc_ctrl_pkg::ADDR_RESULT, 32'hFFF);
    chk_resp(r, adc_ctrl_pkg::RESP_OKAY, "wr result");
    axi(1'b1, adc_ctrl_pkg::ADDR_MASK, 32'h0);
    axi(1'b0, adc_ctrl_pkg::ADDR_RESULT, 32'h0);
    chk_val(q, 32'(smp), "result read only");
    chk_val(32'(irq), 32'(exp_irq(3'h5, 3'h0)), "irq masked");
    axi(1'b1, adc_ctrl_pkg::ADDR_MASK, 32'h1);
    axi(1'b0, adc_ctrl_pkg::ADDR_STATUS, 32'h0);
    chk_val(q, 32'h5, "status pending");
    chk_val(32'(irq), 32'(exp_irq(3'h5, 3'h1)), "irq unmasked");
    axi(1'b1, adc_ctrl_pkg::ADDR_STATUS, 32'h7);
    axi(1'b0, adc_ctrl_pkg::ADDR_STATUS, 32'h0);
    chk_val(q, 32'h0, "status cleared");
    chk_val(32'(irq), 32'h0, "irq cleared");
    close_out;
  end

  // cut a hang well past the expected run length
  initial
  begin
    repeat (40000) @(posedge ref_clk);
    n_fail++;
    close_out;
  end
endmodule
`default_nettype wire
